//--- logic/hwseq_sequencer.sv
// Waveform sequencer with eight slot registers and fire control.
// Assumes a library player outside that reports effect completion.
// Assumes effect_done is a one-cycle pulse from that player
// and that the host never raises both strobes in one cycle.
//
// Functional notes
// - Delay-select set: value times 10 ms wait
// - Delay-select clear: value is waveform identifier
// - Identifier bits 6..0 index the library
// - Fire starts playback at first slot
// - Finished waveform advances to the next slot
// - Walk slots until zero or all eight
// - Zero identifier stops the sequence
// - Fire bit high until process completes
// - Host clearing fire cancels immediately
// - External trigger sets fire like write
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "hwseq_consts.svh"

module hwseq_sequencer (
    // Clock, reset, enable
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    // Register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    // External trigger
    input  wire logic                ext_trigger,
    // Library player
    output logic                     effect_start,
    output logic      [6:0]          slot_effect_index,
    input  wire logic                effect_done,
    output logic                     effect_abort,
    // Status
    output logic                     seq_busy
);
    import hwseq_pkg::*;

    // =========================================================
    // Storage
    logic [7:0]          slot_q [`HWSEQ_NUM_SLOTS];
    logic [7:0]          slot_d [`HWSEQ_NUM_SLOTS];
    logic                fire_q, fire_d;
    hwseq_state_t        state_q, state_d;
    logic [2:0]          ptr_q, ptr_d;
    logic [6:0]          delay_left_q, delay_left_d;
    logic [18:0]         tick_q, tick_d;
    logic [7:0]          rdata_q, rdata_d;
    logic                start_q, start_d;
    logic                abort_q, abort_d;
    logic [6:0]          index_q, index_d;

    // Decode and walk helpers
    logic [7:0]          cur_slot;
    logic [7:0]          slot_off;
    logic                slot_hit;
    logic                host_cancel;
    logic                last_slot;
    logic                step_done;

    // Address decode and slot pointer
    assign cur_slot  = slot_q[ptr_q];
    assign slot_off  = reg_addr - `HWSEQ_ADDR_SLOT_BASE;
    assign slot_hit  = (reg_addr >= `HWSEQ_ADDR_SLOT_BASE)
                    && (reg_addr <= `HWSEQ_ADDR_SLOT_LAST);
    assign last_slot = (ptr_q == 3'(`HWSEQ_NUM_SLOTS - 1));
    assign host_cancel = reg_wr && (reg_addr == `HWSEQ_ADDR_FIRE)
                      && !reg_wdata[`HWSEQ_FIRE_BIT] && fire_q;

    // =========================================================
    // Register writes and read data
    // Slot writes land at the next enabled edge. Reads of an
    // unmapped address return zero and writes there are dropped.
    // Read data stand for one cycle only, then fall back to zero.
    always_comb begin
        for (int i = 0; i < `HWSEQ_NUM_SLOTS; i++) begin
            slot_d[i] = slot_q[i];
        end
        if (reg_wr && slot_hit) begin
            slot_d[slot_off[2:0]] = reg_wdata;
        end
        rdata_d = 8'h00;
        if (reg_rd) begin
            if (slot_hit) begin
                rdata_d = slot_q[slot_off[2:0]];
            end else if (reg_addr == `HWSEQ_ADDR_FIRE) begin
                rdata_d = {7'h00, fire_q};
            end
        end
    end

    // =========================================================
    // Sequencer next state
    // A delay slot of value N keeps the engine idle for N units
    // of 10 ms, each unit counted in clock cycles at 40 MHz.
    // A zero value with the select bit set is an end entry, so
    // a delay slot never passes for no time at all.
    // The walk pointer moves only on a finished slot, or on fire, which returns it to slot one.
    // A host clear overrides every transition below, so an
    // abort pulse and a fresh start never leave in one cycle.
    always_comb begin
        state_d      = state_q;
        ptr_d        = ptr_q;
        fire_d       = fire_q;
        delay_left_d = delay_left_q;
        tick_d       = tick_q;
        start_d      = 1'b0;
        abort_d      = 1'b0;
        index_d      = index_q;
        step_done    = 1'b0;
        unique case (state_q)
            HWSEQ_IDLE: begin
                if ((reg_wr && reg_addr == `HWSEQ_ADDR_FIRE && reg_wdata[`HWSEQ_FIRE_BIT])
                    || ext_trigger) begin
                    fire_d  = 1'b1;
                    ptr_d   = 3'h0;
                    state_d = HWSEQ_FETCH;
                end
            end
            HWSEQ_FETCH: begin
                if (cur_slot[6:0] == 7'h00) begin
                    fire_d  = 1'b0;
                    state_d = HWSEQ_IDLE;
                end else if (cur_slot[`HWSEQ_DELAY_SEL_BIT]) begin
                    delay_left_d = cur_slot[6:0];
                    tick_d       = 19'(`HWSEQ_DELAY_UNIT_CYC - 1);
                    state_d      = HWSEQ_WAIT;
                end else begin
                    index_d = cur_slot[6:0];
                    start_d = 1'b1;
                    state_d = HWSEQ_PLAY;
                end
            end
            // Play waits for the player, wait counts its units down
            HWSEQ_PLAY, HWSEQ_WAIT: begin
                if (state_q == HWSEQ_PLAY) begin
                    step_done = effect_done;
                end else if (tick_q != 19'h00000) begin
                    // Cycle counter first, then the unit count
                    tick_d = tick_q - 19'h00001;
                end else if (delay_left_q == 7'h01) begin
                    step_done = 1'b1;
                end else begin
                    delay_left_d = delay_left_q - 7'h01;
                    tick_d       = 19'(`HWSEQ_DELAY_UNIT_CYC - 1);
                end
                if (step_done) begin
                    if (last_slot) begin
                        fire_d  = 1'b0;
                        state_d = HWSEQ_IDLE;
                    end else begin
                        ptr_d   = ptr_q + 3'h1;
                        state_d = HWSEQ_FETCH;
                    end
                end
            end
        endcase
        if (host_cancel) begin
            abort_d = (state_q == HWSEQ_PLAY);
            fire_d  = 1'b0;
            start_d = 1'b0;
            state_d = HWSEQ_IDLE;
        end
    end

    // =========================================================
    // State registers
    // Clock enable low freezes every register, strobes included,
    // so a host access made while frozen is lost, not delayed.
    always_ff @(posedge clk) begin
        if (rst) begin
            // Slot one resets to a playable index, the rest to end entries
            for (int i = 0; i < `HWSEQ_NUM_SLOTS; i++) begin
                slot_q[i] <= (i == 0) ? `HWSEQ_SLOT1_RESET : `HWSEQ_SLOTN_RESET;
            end
            fire_q       <= 1'b0;
            state_q      <= HWSEQ_IDLE;
            ptr_q        <= 3'h0;
            delay_left_q <= 7'h00;
            tick_q       <= 19'h00000;
            rdata_q      <= 8'h00;
            start_q      <= 1'b0;
            abort_q      <= 1'b0;
            index_q      <= 7'h00;
        end else if (clk_en) begin
            for (int i = 0; i < `HWSEQ_NUM_SLOTS; i++) begin
                slot_q[i] <= slot_d[i];
            end
            fire_q       <= fire_d;
            state_q      <= state_d;
            ptr_q        <= ptr_d;
            delay_left_q <= delay_left_d;
            tick_q       <= tick_d;
            rdata_q      <= rdata_d;
            start_q      <= start_d;
            abort_q      <= abort_d;
            index_q      <= index_d;
        end
    end

    // =========================================================
    // Outputs, all straight from flip-flops
    // seq_busy mirrors the fire bit for the host and the pins
    assign reg_rdata         = rdata_q;
    assign effect_start      = start_q;
    assign effect_abort      = abort_q;
    assign slot_effect_index = index_q;
    assign seq_busy          = fire_q;

endmodule : hwseq_sequencer

//--- logic/hwseq_consts.svh
// Constants for the haptic waveform sequencer slot block.
// Assumes a 40 MHz clock and an 8-bit register port.
`ifndef HWSEQ_CONSTS_SVH
`define HWSEQ_CONSTS_SVH
// =========================================================
// Register offsets
`define HWSEQ_ADDR_FIRE      8'h0C
`define HWSEQ_ADDR_SLOT_BASE 8'h0F
`define HWSEQ_ADDR_SLOT_LAST 8'h16
// =========================================================
// Field positions and reset values
`define HWSEQ_FIRE_BIT       0
`define HWSEQ_DELAY_SEL_BIT  7
`define HWSEQ_SLOT1_RESET    8'h01
`define HWSEQ_SLOTN_RESET    8'h00
`define HWSEQ_NUM_SLOTS      8
// =========================================================
// Timing
`define HWSEQ_CLK_HZ         40000000
`define HWSEQ_DELAY_UNIT_MS  10
`define HWSEQ_DELAY_UNIT_CYC ((`HWSEQ_CLK_HZ / 1000) * `HWSEQ_DELAY_UNIT_MS)
`endif

//--- logic/hwseq_pkg.sv
// Types for the haptic waveform sequencer slot block.
// Assumes hwseq_consts.svh is compiled alongside.
package hwseq_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        HWSEQ_IDLE  = 2'b00,
        HWSEQ_FETCH = 2'b01,
        HWSEQ_PLAY  = 2'b10,
        HWSEQ_WAIT  = 2'b11
    } hwseq_state_t;
endpackage : hwseq_pkg

//--- verification/hwseq_properties.sv
// Port checker for the waveform sequencer.
// Assumes one clock and the bind at the foot.
`timescale 1ns/1ps
`include "hwseq_consts.svh"
module hwseq_properties (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Host side
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       ext_trigger,
    // Player side
    input wire logic       effect_start,
    input wire logic [6:0] slot_effect_index,
    input wire logic       effect_abort,
    input wire logic       seq_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ====================
    // Sequencer relations
    property p_fire;
        reg_wr && clk_en && reg_addr == `HWSEQ_ADDR_FIRE && reg_wdata[0] && !seq_busy |=> seq_busy;
    endproperty
    a_fire: assert property (p_fire) else $error("fire write not taken");
    property p_trig;
        ext_trigger && clk_en && !seq_busy && !reg_wr |=> seq_busy;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not taken");
    property p_rise;
        $rose(seq_busy) |-> $past(reg_wr) || $past(ext_trigger);
    endproperty
    a_rise: assert property (p_rise) else $error("busy rose uncaused");
    property p_zero;
        effect_start |-> slot_effect_index != 7'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("zero index played");
    property p_sbusy;
        effect_start |-> seq_busy;
    endproperty
    a_sbusy: assert property (p_sbusy) else $error("start while idle");
    property p_pulse;
        effect_start && clk_en |=> !effect_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start too long");
    property p_abusy;
        effect_abort && clk_en |-> !seq_busy ##1 !effect_abort;
    endproperty
    a_abusy: assert property (p_abusy) else $error("abort with busy");
    property p_acause;
        $rose(effect_abort) |-> $past(reg_wr) && $past(clk_en)
            && $past(reg_addr) == `HWSEQ_ADDR_FIRE
            && ($past(reg_wdata) & 8'h01) == 8'h00;
    endproperty
    a_acause: assert property (p_acause) else $error("abort uncaused");
    property p_freeze;
        !clk_en && !rst |=> $stable(seq_busy) && $stable(effect_start)
            && $stable(effect_abort) && $stable(slot_effect_index);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    // Main scenarios
    c_start: cover property (effect_start);
    c_abort: cover property (effect_abort);
    c_end: cover property ($fell(seq_busy));
    c_frozen: cover property (!clk_en && reg_wr);
endmodule : hwseq_properties
bind hwseq_sequencer hwseq_properties u_props (.clk(clk), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .ext_trigger(ext_trigger), .effect_start(effect_start),
    .slot_effect_index(slot_effect_index), .effect_abort(effect_abort),
    .seq_busy(seq_busy));

//--- verification/test_hwseq_sequencer.sv
// Bench for the waveform sequencer.
// Assumes the sequencer header and constants.
`timescale 1ns/1ps
module test_hwseq_sequencer;
    logic       clk, rst, clk_en, reg_wr, reg_rd, ext_trigger, effect_done;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [6:0] slot_effect_index;
    logic       effect_start, effect_abort, seq_busy;
    int         fail_count = 0, n_tests = 0, k;
    // Device under test
    hwseq_sequencer dut (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_trigger(ext_trigger), .effect_start(effect_start),
        .slot_effect_index(slot_effect_index), .effect_done(effect_done),
        .effect_abort(effect_abort), .seq_busy(seq_busy));
    // 40 MHz clock
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // ====================
    // Access tasks
    task results;
        if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
        @(posedge clk); reg_wr <= 0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); reg_addr <= a; reg_rd <= 1;
        @(posedge clk); reg_rd <= 0;
        #1 chk("rdata", e, reg_rdata);
    endtask : rd
    task pulse_done;
        @(posedge clk); effect_done <= 1;
        @(posedge clk); effect_done <= 0;
    endtask : pulse_done
    task wait_start(input logic [6:0] idx);
        for (k = 0; k < 20 && effect_start !== 1'b1; k++) @(negedge clk);
        if (k == 20) begin
            chk("start timeout", 8'h01, 8'h00);
            results();
        end
        chk("index", {1'b0, idx}, {1'b0, slot_effect_index});
    endtask : wait_start
    task wait_idle;
        for (k = 0; k < 20 && seq_busy !== 1'b0; k++) begin
            @(negedge clk);
            if (effect_start !== 1'b0) chk("extra start", 8'h00, 8'h01);
        end
        if (k == 20) begin
            chk("idle timeout", 8'h00, 8'h01);
            results();
        end
    endtask : wait_idle
    // ====================
    // Main sequence
    initial begin
        {rst, reg_wr, reg_rd, ext_trigger, effect_done} = 5'h10;
        reg_addr = 8'h00; reg_wdata = 8'h00;
        clk_en = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 0;
        rd(8'h0F, 8'h01);
        rd(8'h0C, 8'h00);
        wr(8'h20, 8'h55); rd(8'h20, 8'h00);
        wr(8'h0F, 8'h05); wr(8'h10, 8'h0A); wr(8'h11, 8'h00);
        wr(8'h0C, 8'h01); wait_start(7'h05);
        rd(8'h0C, 8'h01);
        pulse_done(); wait_start(7'h0A);
        pulse_done(); wait_idle();
        rd(8'h0C, 8'h00);
        // Walk of all eight slots from the trigger pin
        for (int i = 0; i < 8; i++) wr(8'h0F + i[7:0], 8'h11 + i[7:0]);
        @(posedge clk); ext_trigger <= 1;
        @(posedge clk); ext_trigger <= 0;
        for (int i = 0; i < 8; i++) begin
            wait_start(7'h11 + i[6:0]);
            pulse_done();
        end
        wait_idle();
        // Host cancel while playing
        wr(8'h0C, 8'h01); wait_start(7'h11);
        wr(8'h0C, 8'h00);
        for (k = 0; k < 4 && effect_abort !== 1'b1; k++) @(negedge clk);
        chk("abort", 8'h01, {7'h00, effect_abort});
        wait_idle();
        // Delay slot idles the engine until the host clears fire
        wr(8'h0F, 8'h81); wr(8'h0C, 8'h01);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            chk("delay busy", 8'h01, {6'h00, effect_start, seq_busy});
        end
        wr(8'h0C, 8'h00);
        @(negedge clk);
        chk("delay cancel", 8'h00, {6'h00, effect_abort, seq_busy});
        // Delay select with zero wait ends at once
        wr(8'h0F, 8'h80); wr(8'h0C, 8'h01);
        @(negedge clk);
        chk("zero delay busy", 8'h01, {7'h00, seq_busy});
        wait_idle();
        rd(8'h0F, 8'h80);
        // Clock enable low drops host accesses
        @(posedge clk) clk_en <= 1'b0;
        wr(8'h0F, 8'h33); wr(8'h0C, 8'h01);
        clk_en <= 1'b1;
        @(negedge clk);
        chk("frozen fire", 8'h00, {7'h00, seq_busy});
        rd(8'h0F, 8'h80);
        // Reset in mid-delay ends the sequence and restores the slots
        wr(8'h0F, 8'h81); wr(8'h0C, 8'h01);
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        @(negedge clk);
        chk("reset busy", 8'h00, {7'h00, seq_busy});
        rd(8'h0F, 8'h01);
        rd(8'h10, 8'h00);
        results();
    end
endmodule : test_hwseq_sequencer
